// >>> core/rsx_alu.sv
// rsx_alu.sv: combinational result and flag logic for the three operations
// assumes operands are stable from the read quarter onward
`timescale 1ns/100ps
`default_nettype none
module rsx_alu
(
    input  wire rsx_pkg::rsx_kind_t   kind,  // decoded operation
    input  wire logic [7:0]           fval,  // file register value
    input  wire logic [7:0]           wval,  // accumulator value
    input  wire rsx_pkg::rsx_status_t st_in, // flags before
    output logic [7:0]                res,   // result byte
    output rsx_pkg::rsx_status_t      st_out // flags after
);
    logic [8:0] diff;
    logic [4:0] ndiff;

    always_comb
    begin
        diff   = {1'b0, fval} - {1'b0, wval};
        ndiff  = {1'b0, fval[3:0]} - {1'b0, wval[3:0]};
        res    = fval;
        st_out = st_in;
        case (kind)
            rsx_pkg::K_ROTATE_LEFT_VIA_CARRY_OP:
            begin
                res          = {fval[6:0], st_in.carry};        // [RL1]
                st_out.carry = fval[7];                         // [RL1]
            end
            rsx_pkg::K_ROTATE_RIGHT_VIA_CARRY_OP:
            begin
                res          = {st_in.carry, fval[7:1]};        // [RL2]
                st_out.carry = fval[0];                         // [RL2]
            end
            rsx_pkg::K_SUBTRACT_ACC_FROM_FILE_OP:
            begin
                // carry is the inverted borrow
                res                      = diff[7:0];           // [RL5]
                st_out.carry             = ~diff[8];            // [RL5]
                st_out.nibble_carry_flag = ~ndiff[4];           // [RL5]
                st_out.zero              = (diff[7:0] == 8'h00); // [RL5]
            end
            default:
            begin
                res    = fval;
                st_out = st_in;
            end
        endcase
    end
endmodule : rsx_alu
`default_nettype wire

// >>> core/rsx_slice.sv
// rsx_slice.sv: rotate/subtract execution slice with AXI4-Lite access
// assumes one 100 MHz clock, synchronous active-low reset, one quarter
// phase per clock; holds its own 128-byte file register array
// Function
// [RL1] rotate left: carry in bit0, bit7 out
// [RL2] rotate right: carry in bit7, bit0 out
// [RL3] dest bit 0 to accumulator, 1 to file
// [RL4] four quarters: decode, read, compute, write
// [RL5] file minus accumulator; carry, nibble carry, zero
// [RL6] one word, one cycle, address low seven bits
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rsx_defs.svh"
module rsx_slice
(
    input  wire logic        mclk,          // core clock
    input  wire logic        rst_n,         // sync reset, active low
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // byte enables
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready,  // read data ready
    output logic [7:0]       acc_o,         // accumulator
    output rsx_pkg::rsx_status_t flags_o,   // carry, nibble carry, zero
    output logic             busy_o         // instruction in flight
);
    rsx_pkg::rsx_state_t  s_q;
    rsx_pkg::rsx_state_t  s_d;
    logic [7:0]           file_q [0:127];
    logic                 file_we;
    logic [6:0]           file_wa;
    logic [7:0]           file_wd;
    logic [7:0]           alu_res;
    rsx_pkg::rsx_status_t alu_st;
    logic                 start_w;

    function automatic rsx_pkg::rsx_kind_t op_kind(input logic [13:0] op);
        rsx_pkg::rsx_kind_t k;
        k = rsx_pkg::K_NONE;
        if (op[`RSX_OP_HI:`RSX_OP_CLS_LO] == `RSX_CLS_BYTE)
        begin
            case (op[`RSX_OP_CODE_HI:`RSX_OP_CODE_LO])
                `RSX_CODE_RL:  k = rsx_pkg::K_ROTATE_LEFT_VIA_CARRY_OP;
                `RSX_CODE_RR:  k = rsx_pkg::K_ROTATE_RIGHT_VIA_CARRY_OP;
                `RSX_CODE_SUB: k = rsx_pkg::K_SUBTRACT_ACC_FROM_FILE_OP;
                default:       k = rsx_pkg::K_NONE;
            endcase
        end
        return k;
    endfunction : op_kind

    function automatic logic [31:0] reg_read(input logic [2:0] idx,
                                             input rsx_pkg::rsx_state_t s,
                                             input logic [7:0] fd);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (idx)
            `RSX_IDX_INSTR:
            begin
                v[13:0]            = s.op;
                v[`RSX_BUSY_BIT]   = (s.ph != rsx_pkg::PH_IDLE);
            end
            `RSX_IDX_ACC:    v[7:0] = s.acc;
            `RSX_IDX_STATUS: v[2:0] = s.st;
            `RSX_IDX_FADDR:  v[6:0] = s.faddr;
            `RSX_IDX_FDATA:  v[7:0] = fd;
            default:         v      = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_read

    rsx_alu u_alu
    (
        .kind   (s_q.kind),
        .fval   (s_q.fdat),
        .wval   (s_q.acc),
        .st_in  (s_q.st),
        .res    (alu_res),
        .st_out (alu_st)
    );

    always_comb
    begin
        s_d     = s_q;
        file_we = 1'b0;
        file_wa = s_q.faddr;
        file_wd = s_q.w_data[7:0];
        start_w = 1'b0;
        // write channel: address and data taken in either order
        if (s_q.awready && s_axi_awvalid)
        begin
            s_d.aw_ok  = 1'b1;
            s_d.aw_idx = s_axi_awaddr[4:2];
        end
        if (s_q.wready && s_axi_wvalid)
        begin
            s_d.w_ok   = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end
        // commit only while idle so bus writes never race the write quarter
        if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid && s_q.ph == rsx_pkg::PH_IDLE)
        begin
            s_d.aw_ok  = 1'b0;
            s_d.w_ok   = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = `RSX_RESP_OKAY;
            case (s_q.aw_idx)
                `RSX_IDX_INSTR:
                begin
                    if (s_q.w_strb[1:0] == 2'h3)
                    begin
                        s_d.op  = s_q.w_data[13:0];
                        s_d.ph  = rsx_pkg::PH_Q1;
                        start_w = 1'b1;
                    end
                end
                `RSX_IDX_ACC:
                    if (s_q.w_strb[0]) s_d.acc = s_q.w_data[7:0];
                `RSX_IDX_STATUS:
                    if (s_q.w_strb[0]) s_d.st = s_q.w_data[2:0];
                `RSX_IDX_FADDR:
                    if (s_q.w_strb[0]) s_d.faddr = s_q.w_data[6:0];
                `RSX_IDX_FDATA:
                    file_we = s_q.w_strb[0];
                default:
                    s_d.bresp = `RSX_RESP_SLVERR;
            endcase
        end
        // read channel
        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (s_q.arready && s_axi_arvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = reg_read(s_axi_araddr[4:2], s_q, file_q[s_q.faddr]);
            s_d.rresp  = (s_axi_araddr[4:2] > `RSX_IDX_FDATA)
                       ? `RSX_RESP_SLVERR : `RSX_RESP_OKAY;
        end
        // instruction sequencer, one quarter per clock
        case (s_q.ph)
            rsx_pkg::PH_IDLE: s_d.kind = s_d.kind;
            rsx_pkg::PH_Q1:
            begin
                s_d.kind = op_kind(s_q.op);                          // [RL4]
                s_d.ph   = rsx_pkg::PH_Q2;
            end
            rsx_pkg::PH_Q2:
            begin
                s_d.fdat = file_q[s_q.op[`RSX_OP_FA_HI:0]];          // [RL4] [RL6]
                s_d.ph   = rsx_pkg::PH_Q3;
            end
            rsx_pkg::PH_Q3:
            begin
                s_d.res = alu_res;                                   // [RL4]
                s_d.nst = alu_st;
                s_d.ph  = rsx_pkg::PH_Q4;
            end
            rsx_pkg::PH_Q4:
            begin
                // unknown opcodes pass the cycle with no effect
                if (s_q.kind != rsx_pkg::K_NONE)
                begin
                    s_d.st = s_q.nst;                                // [RL1] [RL2] [RL5]
                    if (s_q.op[`RSX_OP_DEST])
                    begin
                        file_we = 1'b1;                              // [RL3]
                        file_wa = s_q.op[`RSX_OP_FA_HI:0];
                        file_wd = s_q.res;
                    end
                    else
                    begin
                        s_d.acc = s_q.res;                           // [RL3]
                    end
                end
                s_d.ph = rsx_pkg::PH_IDLE;                           // [RL6]
            end
            default: s_d.ph = rsx_pkg::PH_IDLE;
        endcase
        s_d.awready = !s_d.aw_ok;
        s_d.wready  = !s_d.w_ok;
        s_d.arready = !s_d.rvalid;
        // registered so busy_o leaves the block straight from a flop
        s_d.busy    = (s_d.ph != rsx_pkg::PH_IDLE);               // [RL4]
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s_q       <= '0;
            s_q.acc   <= `RSX_RST_ACC;
            s_q.faddr <= `RSX_RST_FADDR;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // file contents are not reset, as in a real register file
    always_ff @(posedge mclk)
    begin
        if (file_we)
        begin
            file_q[file_wa] <= file_wd;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign acc_o         = s_q.acc;
    assign flags_o       = s_q.st;
    assign busy_o        = s_q.busy;

    // helper views for assertions
    logic [7:0] fdat_w;
    logic [7:0] acc_w;
    logic [7:0] res_w;
    logic       in_q4;
    assign fdat_w = s_q.fdat;
    assign acc_w  = s_q.acc;
    assign res_w  = s_q.res;
    assign in_q4  = (s_q.ph == rsx_pkg::PH_Q4) && (s_q.kind != rsx_pkg::K_NONE);

    sequence seq_quarters;
        s_q.ph == rsx_pkg::PH_Q1 ##1 s_q.ph == rsx_pkg::PH_Q2
        ##1 s_q.ph == rsx_pkg::PH_Q3 ##1 s_q.ph == rsx_pkg::PH_Q4;
    endsequence

    AST_QUARTERS: assert property (@(posedge mclk) disable iff (!rst_n) // [RL4]
        s_q.ph == rsx_pkg::PH_Q1 |-> seq_quarters ##1 s_q.ph == rsx_pkg::PH_IDLE)
        else $error("quarter phases out of order");

    AST_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!rst_n) // [RL6]
        start_w |=> busy_o [*4] ##1 !busy_o)
        else $error("instruction did not take one cycle");

    AST_ROT_LEFT: assert property (@(posedge mclk) disable iff (!rst_n) // [RL1]
        (in_q4 && s_q.kind == rsx_pkg::K_ROTATE_LEFT_VIA_CARRY_OP)
        |-> res_w == {fdat_w[6:0], s_q.st.carry}
        ##1 s_q.st.carry == $past(fdat_w[7]))
        else $error("rotate left result or carry wrong");

    AST_ROT_RIGHT: assert property (@(posedge mclk) disable iff (!rst_n) // [RL2]
        (in_q4 && s_q.kind == rsx_pkg::K_ROTATE_RIGHT_VIA_CARRY_OP)
        |-> res_w == {s_q.st.carry, fdat_w[7:1]}
        ##1 s_q.st.carry == $past(fdat_w[0]))
        else $error("rotate right result or carry wrong");

    AST_DEST_ACC: assert property (@(posedge mclk) disable iff (!rst_n) // [RL3]
        (in_q4 && !s_q.op[`RSX_OP_DEST]) |-> !file_we ##1 acc_w == $past(res_w))
        else $error("accumulator destination not honoured");

    AST_DEST_FILE: assert property (@(posedge mclk) disable iff (!rst_n) // [RL3]
        (in_q4 && s_q.op[`RSX_OP_DEST])
        |-> file_we && file_wa == s_q.op[6:0] && file_wd == res_w
        ##1 acc_w == $past(acc_w))
        else $error("file destination not honoured");

    AST_SUB_FLAGS: assert property (@(posedge mclk) disable iff (!rst_n) // [RL5]
        (in_q4 && s_q.kind == rsx_pkg::K_SUBTRACT_ACC_FROM_FILE_OP)
        |-> res_w == fdat_w - acc_w
        ##1 s_q.st.carry == ($past(fdat_w) >= $past(acc_w))
        && s_q.st.zero == ($past(fdat_w) == $past(acc_w))
        && s_q.st.nibble_carry_flag
           == ($past(fdat_w[3:0]) >= $past(acc_w[3:0])))
        else $error("subtract result or flags wrong");

endmodule : rsx_slice
`default_nettype wire

// >>> dv/test_rsx_slice.sv
// test_rsx_slice.sv: self-checking bench for the rotate/subtract slice
// assumes rsx_pkg is compiled first and rsx_defs.svh is on the include path
`timescale 1ns/100ps
`default_nettype none
`include "rsx_defs.svh"
module test_rsx_slice;
    logic                 mclk;
    logic                 rst_n;
    logic [7:0]           s_axi_awaddr;
    logic                 s_axi_awvalid;
    logic                 s_axi_awready;
    logic [31:0]          s_axi_wdata;
    logic [3:0]           s_axi_wstrb;
    logic                 s_axi_wvalid;
    logic                 s_axi_wready;
    logic [1:0]           s_axi_bresp;
    logic                 s_axi_bvalid;
    logic                 s_axi_bready;
    logic [7:0]           s_axi_araddr;
    logic                 s_axi_arvalid;
    logic                 s_axi_arready;
    logic [31:0]          s_axi_rdata;
    logic [1:0]           s_axi_rresp;
    logic                 s_axi_rvalid;
    logic                 s_axi_rready;
    logic [7:0]           acc_o;
    rsx_pkg::rsx_status_t flags_o;
    logic                 busy_o;
    integer               seed;
    int                   mismatches;
    int                   comparisons;
    int                   busy_cnt;
    int                   i;
    logic [3:0]           code;
    logic [7:0]           f, w, rd8;
    logic [6:0]           fa;
    logic [2:0]           st;
    logic                 d, ok;
    logic [10:0]          ex;
    logic [31:0]          rd;
    logic [1:0]           rr;
    // worked cases first: rotates of 0xE6, subtract to positive, zero, negative
    logic [3:0] c_code [6] = '{4'hD, 4'hC, 4'h2, 4'h2, 4'h2, 4'h2};
    logic [7:0] c_f    [6] = '{8'hE6, 8'hE6, 8'h03, 8'h02, 8'h01, 8'h10};
    logic [7:0] c_w    [6] = '{8'h5A, 8'hA5, 8'h02, 8'h02, 8'h02, 8'h01};
    logic [2:0] c_st   [6] = '{3'h0, 3'h6, 3'h0, 3'h0, 3'h7, 3'h0};
    logic       c_d    [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [3:0] codes  [4] = '{4'hD, 4'hC, 4'h2, 4'h7};

    rsx_slice rsx_slice_inst
    (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .acc_o         (acc_o),
        .flags_o       (flags_o),
        .busy_o        (busy_o)
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // counts edges that see an instruction in flight
    always @(posedge mclk)
        if (busy_o === 1'b1)
            busy_cnt <= busy_cnt + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                mismatches++;
                $display("MISMATCH at %0t: %s seen %h expected %h",
                         $time, what, seen, exp);
            end
        end
    endtask : check

    task automatic print_verdict();
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask : print_verdict

    // address and data offered together, each released once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] dat,
                             output logic [1:0] resp);
        int n;
        begin
            n = 0;
            resp = 2'h3;
            @(posedge mclk);
            s_axi_awaddr  <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata   <= dat;
            s_axi_wstrb   <= 4'hF;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
            while (n < 60)
            begin
                @(posedge mclk);
                n++;
                if (s_axi_awvalid && s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid === 1'b1)
                begin
                    resp = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    n = 100;
                end
            end
            if (n < 100)
                check(32'h0, 32'h1, "write never answered");
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] dat,
                            output logic [1:0] resp);
        int n;
        begin
            n = 0;
            dat = 32'hFFFFFFFF;
            resp = 2'h3;
            @(posedge mclk);
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
            while (n < 60)
            begin
                @(posedge mclk);
                n++;
                if (s_axi_arvalid && s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid === 1'b1)
                begin
                    dat = s_axi_rdata;
                    resp = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                    n = 100;
                end
            end
            if (n < 100)
                check(32'h0, 32'h1, "read never answered");
        end
    endtask : axi_read

    // returns {zero, nibble carry, carry, result}
    function automatic logic [10:0] ref_exec(input logic [3:0] op,
        input logic [7:0] fv, input logic [7:0] wv, input logic [2:0] sv);
        logic [7:0] r;
        logic [2:0] s;
        begin
            r = fv;
            s = sv;
            case (op)
                4'hD: begin r = {fv[6:0], sv[0]}; s[0] = fv[7]; end
                4'hC: begin r = {sv[0], fv[7:1]}; s[0] = fv[0]; end
                4'h2: begin r = fv - wv;
                    s = {r == 8'h00, fv[3:0] >= wv[3:0], fv >= wv}; end
                default: ;
            endcase
            return {s, r};
        end
    endfunction : ref_exec

    initial
    begin
        seed = 32'h3C89A8AF;
        mismatches = 0;
        comparisons = 0;
        busy_cnt = 0;
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        axi_read(8'h14, rd, rr);
        check({30'h0, rr}, {30'h0, `RSX_RESP_SLVERR}, "unmapped read resp");
        check(rd, 32'h0, "unmapped read data");
        axi_write(8'h18, 32'h0000_0000, rr);
        check({30'h0, rr}, {30'h0, `RSX_RESP_SLVERR}, "unmapped write resp");
        for (i = 0; i < 60; i++)
        begin
            fa = 7'($random(seed));
            if (i < 6)
            begin
                code = c_code[i]; f = c_f[i]; w = c_w[i];
                st = c_st[i]; d = c_d[i];
            end
            else
            begin
                code = codes[$unsigned($random(seed)) % 4];
                f  = 8'($random(seed));
                w  = 8'($random(seed));
                st = 3'($random(seed));
                d  = 1'($random(seed));
            end
            axi_write(8'h0C, {25'h0, fa}, rr);
            axi_write(8'h10, {24'h0, f}, rr);
            axi_write(8'h04, {24'h0, w}, rr);
            axi_write(8'h08, {29'h0, st}, rr);
            check({30'h0, rr}, {30'h0, `RSX_RESP_OKAY}, "setup resp");
            busy_cnt = 0;
            axi_write(8'h00, {18'h0, 2'b00, code, d, fa}, rr);
            while (busy_o !== 1'b0 && busy_cnt < 20)
                @(posedge mclk);
            #1;
            ex = ref_exec(code, f, w, st);
            ok = (code == 4'hD) || (code == 4'hC) || (code == 4'h2);
            rd8 = (ok && !d) ? ex[7:0] : w;
            check({24'h0, acc_o}, {24'h0, rd8}, "acc");
            check({29'h0, flags_o}, {29'h0, ok ? ex[10:8] : st}, "flags");
            check(32'(busy_cnt), 32'h4, "busy span");
            axi_read(8'h10, rd, rr);
            rd8 = (ok && d) ? ex[7:0] : f;
            check(rd, {24'h0, rd8}, "file byte");
            axi_read(8'h00, rd, rr);
            check(rd, {18'h0, 2'b00, code, d, fa}, "instr readback");
        end
        print_verdict();
    end

    // run needs roughly 1,800 cycles; generous margin before giving up
    initial
    begin
        repeat (20000) @(posedge mclk);
        check(32'h0, 32'h1, "watchdog expired");
        print_verdict();
    end
endmodule : test_rsx_slice
`default_nettype wire

// >>> inc/rsx_defs.svh
// rsx_defs.svh: offsets, field positions, reset values and response codes
// assumes inclusion by bare name from design and bench files
`ifndef RSX_DEFS_SVH
`define RSX_DEFS_SVH

// register word indices (byte address = index * 4)
`define RSX_IDX_INSTR   3'h0
`define RSX_IDX_ACC     3'h1
`define RSX_IDX_STATUS  3'h2
`define RSX_IDX_FADDR   3'h3
`define RSX_IDX_FDATA   3'h4

// instruction word fields
`define RSX_OP_HI       13
`define RSX_OP_CLS_LO   12
`define RSX_OP_CODE_HI  11
`define RSX_OP_CODE_LO  8
`define RSX_OP_DEST     7
`define RSX_OP_FA_HI    6

// opcode values in bits 11:8, bits 13:12 zero
`define RSX_CODE_RL     4'hD
`define RSX_CODE_RR     4'hC
`define RSX_CODE_SUB    4'h2
`define RSX_CLS_BYTE    2'h0

// bit positions in the status word, and the busy bit of the instruction word
`define RSX_ST_CARRY    0
`define RSX_ST_NIBBLE   1
`define RSX_ST_ZERO     2
`define RSX_BUSY_BIT    31

// reset values
`define RSX_RST_ACC     8'h00
`define RSX_RST_FADDR   7'h00

// bus answers
`define RSX_RESP_OKAY   2'h0
`define RSX_RESP_SLVERR 2'h2

`endif

// >>> inc/rsx_pkg.sv
// rsx_pkg.sv: types for the rotate/subtract execution slice
// assumes rsx_defs.svh is on the include path
package rsx_pkg;

    typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} rsx_phase_t;

    typedef enum logic [1:0]
    {
        K_NONE,
        K_ROTATE_LEFT_VIA_CARRY_OP,
        K_ROTATE_RIGHT_VIA_CARRY_OP,
        K_SUBTRACT_ACC_FROM_FILE_OP
    } rsx_kind_t;

    typedef struct packed {
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } rsx_status_t;

    typedef struct packed {
        logic        aw_ok;
        logic [2:0]  aw_idx;
        logic        w_ok;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        rsx_phase_t  ph;
        rsx_kind_t   kind;
        logic [13:0] op;
        logic [7:0]  fdat;
        logic [7:0]  res;
        rsx_status_t nst;
        logic [7:0]  acc;
        rsx_status_t st;
        logic [6:0]  faddr;
        logic        busy;
    } rsx_state_t;

endpackage : rsx_pkg
